// file: sfpc_buf_ram.sv
// Byte-wide buffer memory with registered read data
module sfpc_buf_ram #(
  parameter int AW = 11, // Address width
  parameter int DW = 8 // Data width
) (
  input wire logic clk_i, // Core clock
  input wire logic wr_en_i, // Write strobe
  input wire logic [AW-1:0] wr_addr_i, // Write address
  input wire logic [DW-1:0] wr_data_i, // Write data
  input wire logic rd_en_i, // Read strobe
  input wire logic [AW-1:0] rd_addr_i, // Read address
  output logic [DW-1:0] rd_data_o // Read data, one cycle after strobe
);

  logic [DW-1:0] mem [0:(2**AW)-1];

  // Write port
  always_ff @(posedge clk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  // Registered read port
  always_ff @(posedge clk_i) begin
    if (rd_en_i) begin
      rd_data_o <= mem[rd_addr_i];
    end
  end

endmodule

// file: sfpc_host_model.sv
// Host model driving the serial link, clock idle low between frames
module sfpc_host_model (
  input wire logic clk_i, // Core clock
  input wire logic so_i, // Resolved serial data out
  output logic sck_o, // Serial clock
  output logic cs_n_o, // Chip select
  output logic si_o // Serial data in
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
  end
  // Wait n core cycles, then settle just past the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // One frame: send bytes, then read nrd bytes, 80 ns clock
  task automatic frame(input logic [7:0] tx[$], input int nrd,
                       output logic [7:0] rx[$]);
    logic [7:0] b;
    rx = {};
    tick(1);
    cs_n_o = 1'b0;
    foreach (tx[i]) for (int k = 7; k >= 0; k--) begin
      si_o = tx[i][k];
      tick(4);
      sck_o = 1'b1;
      tick(4);
      sck_o = 1'b0;
    end
    for (int j = 0; j < nrd; j++) begin
      for (int k = 7; k >= 0; k--) begin
        tick(4);
        sck_o = 1'b1;
        b[k] = so_i;
        tick(4);
        sck_o = 1'b0;
      end
      rx.push_back(b);
    end
    tick(4);
    cs_n_o = 1'b1;
    si_o = ~si_o;
    tick(6);
  endtask
endmodule

// file: sfpc_pin_ctrl.sv
// Serial flash pin control: frame decode, protection, busy and reset
//
// How it works
// - Every command, address and data bit is taken from SI on SCK rise.
// - SI is sampled only on rising SCK edges, never on falling ones.
// - SO moves to its next bit only on a falling SCK edge.
// - WP low blocks program and erase of every sector, marked protected or not.
// - Hardware protection acts whether or not software protection is on.
// - While WP is low the sector protection register cannot change; the reset pin still clears it.
// - Program or erase arriving with WP low is dropped, nothing runs.
// - After a dropped command the device idles when CS rises.
// - An open WP pin reads high, so protection is off.
// - Reset pin low aborts any operation and idles the state machine.
// - Reset holds as long as the reset pin stays low.
// - Normal operation resumes when the reset pin is high again.
// - An internal power-on reset needs no reset pin sequence.
// - Ready/busy is pulled low during self-timed work, else released.
// - Busy covers program, erase, compare and page to buffer transfer.
// - While busy the array is closed; program, compare and transfer also close their buffer, the other works.
// - Programming always writes one whole page.
// - Erase works on the whole chip, a sector, a block or a page.
// - Operations start on CS fall and end on CS rise only; the reset pin also ends a frame, and self-timed work starts on CS rise.
// - Standby after a self-timed operation waits for it to finish.
// - Opcodes, addresses and data travel most significant bit first.
module sfpc_pin_ctrl #(
  parameter int PAGE_BYTES = sfpc_pkg::PAGE_BYTES_DEF,
  parameter int SECTORS = sfpc_pkg::SECTORS_DEF,
  parameter int PROG_CYC = sfpc_pkg::PROG_CYC_DEF,
  parameter int ER_PAGE_CYC = sfpc_pkg::ER_PAGE_CYC_DEF,
  parameter int ER_BLOCK_CYC = sfpc_pkg::ER_BLOCK_CYC_DEF,
  parameter int ER_SECTOR_CYC = sfpc_pkg::ER_SECTOR_CYC_DEF,
  parameter int ER_CHIP_CYC = sfpc_pkg::ER_CHIP_CYC_DEF,
  parameter int XFER_CYC = sfpc_pkg::XFER_CYC_DEF,
  parameter int CMP_CYC = sfpc_pkg::CMP_CYC_DEF
) (
  input wire logic CORE_CLK_I, // Core clock, 100 MHz
  input wire logic RST_I, // Power-on reset, sync, high
  input wire logic SCK_I, // Serial clock pin
  input wire logic CS_N_I, // Chip select pin, low active
  input wire logic SI_I, // Serial data in pin
  input wire logic WP_N_I, // Write protect pin, low active
  input wire logic RESET_N_I, // Reset pin, low active
  output logic SO_O, // Serial data out
  output logic SO_OE_O, // Serial data out enable
  output logic RDY_BUSY_N_O, // Ready/busy open-drain level
  output logic RDY_BUSY_N_OE_O // Ready/busy pull-down enable
);

  localparam int SEC_W = $clog2(SECTORS);
  localparam int AW = sfpc_pkg::BYTE_AW + sfpc_pkg::PAGE_AW;
  localparam int CW = sfpc_pkg::BUSY_CW;

  // Refuse sizes the address layout cannot serve
  if (PAGE_BYTES < 2 || PAGE_BYTES > (2**sfpc_pkg::BYTE_AW)) begin : g_bad_pg
    $error("PAGE_BYTES out of range");
  end
  if (SECTORS < 2 || (2**SEC_W) != SECTORS || SEC_W > sfpc_pkg::PAGE_AW)
  begin : g_bad_sec
    $error("SECTORS must be a power of two within the page range");
  end
  if (PROG_CYC < 1 || ER_CHIP_CYC >= (2**CW) || ER_SECTOR_CYC >= (2**CW))
  begin : g_bad_cyc
    $error("Busy cycle counts out of range");
  end

  // Pin synchronisers, two flops each
  logic [4:0] meta_r;
  logic [4:0] sync_r;
  logic sck_d_r;
  logic cs_n_d_r;
  wire sck_s = sync_r[0];
  wire cs_n_s = sync_r[1];
  wire si_s = sync_r[2];
  wire wp_n_s = sync_r[3];
  wire reset_n_s = sync_r[4];

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      meta_r <= sfpc_pkg::PIN_RST_VAL;
      sync_r <= sfpc_pkg::PIN_RST_VAL;
      sck_d_r <= 1'b0;
      cs_n_d_r <= 1'b1;
    end else begin
      meta_r <= {RESET_N_I, WP_N_I, SI_I, CS_N_I, SCK_I};
      sync_r <= meta_r;
      sck_d_r <= sck_s;
      cs_n_d_r <= cs_n_s;
    end
  end

  // Edge events and the internal reset
  wire sck_rise = sck_s & ~sck_d_r & ~cs_n_s;
  wire sck_fall = ~sck_s & sck_d_r & ~cs_n_s;
  wire cs_fall = ~cs_n_s & cs_n_d_r;
  wire cs_rise = cs_n_s & ~cs_n_d_r;
  wire int_rst = RST_I | ~reset_n_s;

  // Frame state and shift registers
  sfpc_pkg::sfpc_state_type state_r;
  sfpc_pkg::sfpc_state_type state_nxt;
  logic [2:0] bit_cnt_r;
  logic [6:0] sh_r;
  logic [7:0] opc_r;
  logic [AW-1:0] addr_r;
  logic [1:0] abyte_r;
  logic [sfpc_pkg::BYTE_AW-1:0] baddr_r;
  logic [SEC_W-1:0] spr_idx_r;
  logic [SECTORS-1:0] spr_r;
  logic sw_prot_r;
  logic rd_pend_r;
  logic so_r;
  logic [6:0] out_sh_r;
  logic [2:0] out_cnt_r;
  logic busy_r;
  logic [CW-1:0] busy_cnt_r;
  logic busy_buf_vld_r;
  logic busy_buf_r;
  logic [7:0] rd_data;

  // Byte assembly, most significant bit first
  wire [7:0] byte_in = {sh_r, si_s};
  wire byte_done = sck_rise & (bit_cnt_r == 3'h7);
  wire [AW-1:0] addr_full = {addr_r[AW-9:0], byte_in};
  wire addr_last = byte_done & (abyte_r == 2'(sfpc_pkg::ADDR_BYTES - 1));
  wire buf_sel = opc_r[1];

  // Opcode classes
  wire op_is_wr = (opc_r == sfpc_pkg::OP_BUF_WR1) |
                  (opc_r == sfpc_pkg::OP_BUF_WR2);
  wire op_is_rd = (opc_r == sfpc_pkg::OP_BUF_RD1) |
                  (opc_r == sfpc_pkg::OP_BUF_RD2);
  wire op_is_prog = (opc_r == sfpc_pkg::OP_PROG1) |
                    (opc_r == sfpc_pkg::OP_PROG2);
  wire op_is_bufop = op_is_prog |
                     (opc_r == sfpc_pkg::OP_XFER1) |
                     (opc_r == sfpc_pkg::OP_XFER2) |
                     (opc_r == sfpc_pkg::OP_CMP1) |
                     (opc_r == sfpc_pkg::OP_CMP2);
  wire op_is_chip = (opc_r == sfpc_pkg::OP_ER_CHIP);
  wire op_is_erase = (opc_r == sfpc_pkg::OP_ER_PAGE) |
                     (opc_r == sfpc_pkg::OP_ER_BLOCK) |
                     (opc_r == sfpc_pkg::OP_ER_SECTOR) | op_is_chip;
  wire op_is_pe = op_is_prog | op_is_erase;
  wire op_is_timed = op_is_bufop | op_is_erase;
  wire op_is_spr = (opc_r == sfpc_pkg::OP_PROT_WR);

  // Classes of the opcode byte as it completes
  wire in_needs_addr = (byte_in[7:4] >= 4'h2) & (byte_in[7:4] <= 4'h7) &
                       (byte_in[3:0] >= 4'h1) &
                       (byte_in[3:0] <= ((byte_in[7:4] == 4'h7) ?
                                         4'h4 : 4'h2));

  // Buffer collision with a running operation
  wire buf_blocked = busy_r & busy_buf_vld_r & (busy_buf_r == buf_sel);

  // Protection check at launch time
  wire [SEC_W-1:0] tgt_sec = addr_r[AW-1 -: SEC_W];
  wire tgt_prot = op_is_chip ? (|spr_r) : spr_r[tgt_sec];
  wire hw_block = ~wp_n_s;
  wire sw_block = sw_prot_r & tgt_prot;
  wire pe_blocked = op_is_pe & (hw_block | sw_block);
  wire launch = (state_r == sfpc_pkg::ST_ARM) & cs_rise & ~pe_blocked;

  // Length of the self-timed operation; programs always cover one page
  wire [CW-1:0] op_len =
    op_is_prog ? CW'(PROG_CYC) :
    (opc_r == sfpc_pkg::OP_ER_PAGE) ? CW'(ER_PAGE_CYC) :
    (opc_r == sfpc_pkg::OP_ER_BLOCK) ? CW'(ER_BLOCK_CYC) :
    (opc_r == sfpc_pkg::OP_ER_SECTOR) ? CW'(ER_SECTOR_CYC) :
    op_is_chip ? CW'(ER_CHIP_CYC) :
    ((opc_r == sfpc_pkg::OP_XFER1) | (opc_r == sfpc_pkg::OP_XFER2)) ?
      CW'(XFER_CYC) : CW'(CMP_CYC);

  // Buffer memory ports
  wire in_wdata = (state_r == sfpc_pkg::ST_WDATA);
  wire in_rdata = (state_r == sfpc_pkg::ST_RDATA);
  wire mem_wr = in_wdata & byte_done & ~op_is_spr;
  wire [sfpc_pkg::BYTE_AW:0] mem_addr = {buf_sel, baddr_r};
  wire spr_wr = in_wdata & byte_done & op_is_spr & wp_n_s;
  wire [sfpc_pkg::BYTE_AW-1:0] baddr_inc =
    (baddr_r >= sfpc_pkg::BYTE_AW'(PAGE_BYTES - 1)) ?
    '0 : baddr_r + 1'b1;
  wire load_byte = in_rdata & sck_fall & (out_cnt_r == 3'h0);

  sfpc_buf_ram #(
    .AW(sfpc_pkg::BYTE_AW + 1),
    .DW(8)
  ) u_buf (
    .clk_i(CORE_CLK_I),
    .wr_en_i(mem_wr),
    .wr_addr_i(mem_addr),
    .wr_data_i(byte_in),
    .rd_en_i(rd_pend_r),
    .rd_addr_i(mem_addr),
    .rd_data_o(rd_data)
  );

  // Next frame state; CS high always returns to idle
  always_comb begin
    state_nxt = state_r;
    if (cs_n_s) begin
      state_nxt = sfpc_pkg::ST_IDLE;
    end else begin
      case (state_r)
        sfpc_pkg::ST_IDLE: begin
          if (cs_fall) begin
            state_nxt = sfpc_pkg::ST_OPC;
          end
        end
        sfpc_pkg::ST_OPC: begin
          if (byte_done) begin
            if (in_needs_addr) begin
              state_nxt = sfpc_pkg::ST_ADDR;
            end else if (byte_in == sfpc_pkg::OP_PROT_WR) begin
              state_nxt = sfpc_pkg::ST_WDATA;
            end else begin
              state_nxt = sfpc_pkg::ST_IGNORE;
            end
          end
        end
        sfpc_pkg::ST_ADDR: begin
          if (addr_last) begin
            if ((op_is_wr | op_is_rd) & buf_blocked) begin
              state_nxt = sfpc_pkg::ST_IGNORE;
            end else if (op_is_wr) begin
              state_nxt = sfpc_pkg::ST_WDATA;
            end else if (op_is_rd) begin
              state_nxt = sfpc_pkg::ST_RDATA;
            end else if (op_is_timed & ~busy_r) begin
              state_nxt = sfpc_pkg::ST_ARM;
            end else begin
              state_nxt = sfpc_pkg::ST_IGNORE;
            end
          end
        end
        default: begin
          state_nxt = state_r;
        end
      endcase
    end
  end

  // Frame state register
  always_ff @(posedge CORE_CLK_I) begin
    if (int_rst) begin
      state_r <= sfpc_pkg::ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Input shifting on rising SCK edges
  always_ff @(posedge CORE_CLK_I) begin
    if (int_rst || cs_fall) begin
      bit_cnt_r <= 3'h0;
      sh_r <= 7'h00;
    end else if (sck_rise) begin
      bit_cnt_r <= bit_cnt_r + 3'h1;
      sh_r <= byte_in[6:0];
    end
  end

  // Opcode and address capture
  always_ff @(posedge CORE_CLK_I) begin
    if (int_rst || cs_fall) begin
      opc_r <= 8'h00;
      addr_r <= '0;
      abyte_r <= 2'h0;
    end else if (byte_done && state_r == sfpc_pkg::ST_OPC) begin
      opc_r <= byte_in;
    end else if (byte_done && state_r == sfpc_pkg::ST_ADDR) begin
      addr_r <= addr_full;
      abyte_r <= abyte_r + 2'h1;
    end
  end

  // Buffer byte pointer for writes and reads
  always_ff @(posedge CORE_CLK_I) begin
    if (int_rst) begin
      baddr_r <= '0;
    end else if (addr_last && state_r == sfpc_pkg::ST_ADDR) begin
      baddr_r <= addr_full[sfpc_pkg::BYTE_AW-1:0];
    end else if (mem_wr || rd_pend_r) begin
      baddr_r <= baddr_inc;
    end
  end

  // Sector protection register and software enable
  always_ff @(posedge CORE_CLK_I) begin
    if (int_rst) begin
      spr_r <= '0;
      spr_idx_r <= '0;
      sw_prot_r <= 1'b0;
    end else begin
      if (cs_fall) begin
        spr_idx_r <= '0;
      end else if (spr_wr) begin
        spr_r[spr_idx_r] <= |byte_in;
        spr_idx_r <= spr_idx_r + 1'b1;
      end
      if (byte_done && state_r == sfpc_pkg::ST_OPC) begin
        if (byte_in == sfpc_pkg::OP_PROT_EN) begin
          sw_prot_r <= 1'b1;
        end else if (byte_in == sfpc_pkg::OP_PROT_DIS && wp_n_s) begin
          sw_prot_r <= 1'b0;
        end
      end
    end
  end

  // Read prefetch and output shifting on falling SCK edges
  always_ff @(posedge CORE_CLK_I) begin
    if (int_rst || cs_fall) begin
      rd_pend_r <= 1'b0;
      so_r <= 1'b0;
      out_sh_r <= 7'h00;
      out_cnt_r <= 3'h0;
    end else begin
      rd_pend_r <= (addr_last & op_is_rd & ~buf_blocked &
                    state_r == sfpc_pkg::ST_ADDR) | load_byte;
      if (in_rdata && sck_fall) begin
        out_cnt_r <= out_cnt_r + 3'h1;
        if (load_byte) begin
          so_r <= rd_data[7];
          out_sh_r <= rd_data[6:0];
        end else begin
          so_r <= out_sh_r[6];
          out_sh_r <= {out_sh_r[5:0], 1'b0};
        end
      end
    end
  end

  // Self-timed operation timer; runs on past the end of the frame
  always_ff @(posedge CORE_CLK_I) begin
    if (int_rst) begin
      busy_r <= 1'b0;
      busy_cnt_r <= '0;
      busy_buf_vld_r <= 1'b0;
      busy_buf_r <= 1'b0;
    end else if (launch) begin
      busy_r <= 1'b1;
      busy_cnt_r <= op_len - 1'b1;
      busy_buf_vld_r <= op_is_bufop;
      busy_buf_r <= buf_sel;
    end else if (busy_r) begin
      if (busy_cnt_r == '0) begin
        busy_r <= 1'b0;
        busy_buf_vld_r <= 1'b0;
      end else begin
        busy_cnt_r <= busy_cnt_r - 1'b1;
      end
    end
  end

  // Pin drivers
  assign SO_O = so_r;
  assign SO_OE_O = in_rdata & ~cs_n_s;
  assign RDY_BUSY_N_O = 1'b0;
  assign RDY_BUSY_N_OE_O = busy_r;

endmodule

// file: sfpc_pin_ctrl_bench.sv
// Self-checking bench for the serial flash pin control block
module sfpc_pin_ctrl_bench;
  timeunit 1ns;
  timeprecision 100ps;
  typedef logic [7:0] sfpc_bytes_type[$];
  localparam int PB = 528;
  localparam int PROG = 2000;
  localparam int EP = 30;
  localparam int EB = 40;
  localparam int ES = 50;
  localparam int EC = 60;
  localparam int XF = 35;
  localparam int CM = 45;
  logic clk, rst, wp_n, reset_n, tgl, oe_seen;
  logic sck, cs_n, si, so, so_oe, rdy, rdy_oe, so_w, rdy_w;
  logic [15:0] lfsr = 16'hFECD;
  logic [63:0] prot = 64'h0;
  logic sw_en = 1'b0;
  logic [7:0] mem[int];
  logic [7:0] rx[$];
  int miscompares, n_tests, cyc, run, last_len, o;
  logic [7:0] ops[10] = '{sfpc_pkg::OP_PROG1, sfpc_pkg::OP_PROG2,
    sfpc_pkg::OP_XFER1, sfpc_pkg::OP_XFER2, sfpc_pkg::OP_CMP1,
    sfpc_pkg::OP_CMP2, sfpc_pkg::OP_ER_PAGE, sfpc_pkg::OP_ER_BLOCK,
    sfpc_pkg::OP_ER_SECTOR, sfpc_pkg::OP_ER_CHIP};
  // Released lines: serial out toggles, ready/busy pulled up
  assign so_w = so_oe ? so : tgl;
  assign rdy_w = rdy_oe ? rdy : 1'b1;
  sfpc_pin_ctrl #(.PROG_CYC(PROG), .ER_PAGE_CYC(EP), .ER_BLOCK_CYC(EB),
    .ER_SECTOR_CYC(ES), .ER_CHIP_CYC(EC), .XFER_CYC(XF), .CMP_CYC(CM)
  ) u_dut (
    .CORE_CLK_I(clk), .RST_I(rst), .SCK_I(sck), .CS_N_I(cs_n), .SI_I(si),
    .WP_N_I(wp_n), .RESET_N_I(reset_n), .SO_O(so), .SO_OE_O(so_oe),
    .RDY_BUSY_N_O(rdy), .RDY_BUSY_N_OE_O(rdy_oe)
  );
  sfpc_host_model u_host (.clk_i(clk), .so_i(so_w), .sck_o(sck),
    .cs_n_o(cs_n), .si_o(si));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Cycle ceiling of about 2.4 times the run, busy length, read watch
  always @(posedge clk) begin
    tgl <= ~tgl;
    if (so_oe === 1'b1) oe_seen = 1'b1;
    if (rdy_w === 1'b0) run++;
    else if (run != 0) begin
      last_len = run;
      run = 0;
    end
    cyc++;
    if (cyc == 60000) begin
      miscompares++;
      end_of_test();
    end
  end
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr[7:0];
  endfunction
  function automatic sfpc_bytes_type hdr(input logic [7:0] op,
                                         input logic [23:0] a);
    return '{op, a[23:16], a[15:8], a[7:0]};
  endfunction
  // Model: busy length expected for a timed operation, 0 if refused
  function automatic int exp_len(input logic [7:0] op,
                                 input logic [23:0] a);
    int n;
    logic hit;
    case (op)
      sfpc_pkg::OP_PROG1, sfpc_pkg::OP_PROG2: n = PROG;
      sfpc_pkg::OP_XFER1, sfpc_pkg::OP_XFER2: n = XF;
      sfpc_pkg::OP_CMP1, sfpc_pkg::OP_CMP2: n = CM;
      sfpc_pkg::OP_ER_PAGE: n = EP;
      sfpc_pkg::OP_ER_BLOCK: n = EB;
      sfpc_pkg::OP_ER_SECTOR: n = ES;
      default: n = EC;
    endcase
    hit = (op == sfpc_pkg::OP_ER_CHIP) ? |prot : prot[a[22:17]];
    if (n != XF && n != CM && (!wp_n || (sw_en && hit))) n = 0;
    return n;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task automatic bw(input int b, input int off, input int n);
    logic [7:0] tx[$];
    logic [7:0] d;
    tx = hdr(b ? sfpc_pkg::OP_BUF_WR2 : sfpc_pkg::OP_BUF_WR1, 24'(off));
    for (int i = 0; i < n; i++) begin
      d = rnd();
      tx.push_back(d);
      mem[b * 1024 + (off + i) % PB] = d;
    end
    u_host.frame(tx, 0, rx);
  endtask
  task automatic br(input int b, input int off, input int n);
    u_host.frame(hdr(b ? sfpc_pkg::OP_BUF_RD2 : sfpc_pkg::OP_BUF_RD1,
      24'(off)), n, rx);
    foreach (rx[i]) chk(rx[i], mem[b * 1024 + (off + i) % PB]);
  endtask
  task automatic fin();
    repeat (6000) if (rdy_w === 1'b0) @(posedge clk);
    u_host.tick(2);
  endtask
  task automatic top(input logic [7:0] op, input logic [23:0] a);
    int e;
    e = exp_len(op, a);
    last_len = 0;
    u_host.frame(hdr(op, a), 0, rx);
    fin();
    chk(last_len, e);
  endtask
  task automatic prw(input logic [63:0] m);
    logic [7:0] tx[$];
    tx = '{sfpc_pkg::OP_PROT_WR};
    for (int k = 0; k < 64; k++) tx.push_back({7'h00, m[k]});
    u_host.frame(tx, 0, rx);
    if (wp_n) prot = m;
  endtask
  task automatic sw(input logic [7:0] op);
    u_host.frame('{op}, 0, rx);
    if (op == sfpc_pkg::OP_PROT_EN) sw_en = 1'b1;
    else if (wp_n) sw_en = 1'b0;
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    reset_n = 1'b1;
    wp_n = 1'b1;
    tgl = 1'b0;
    oe_seen = 1'b0;
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    u_host.tick(6);
    // Writes across the page end, read back from both buffers
    for (int b = 0; b < 2; b++) begin
      // Buffer traffic must pass whatever the protect pin shows
      wp_n = b[0];
      bw(b, PB - 1, 3);
      br(b, PB - 1, 3);
    end
    $display("buffer test done");
    foreach (ops[i]) top(ops[i], {1'b0, 13'(i), 10'h000});
    $display("timed test done");
    // Write protect low drops marks, program and erase
    wp_n = 1'b0;
    prw(64'h1);
    foreach (ops[i]) top(ops[i], 24'h0);
    wp_n = 1'b1;
    sw(sfpc_pkg::OP_PROT_EN);
    top(sfpc_pkg::OP_ER_PAGE, 24'h0);
    $display("hardware protect test done");
    // Software protection of sector one only
    prw(64'h2);
    top(sfpc_pkg::OP_ER_SECTOR, 24'h020000);
    top(sfpc_pkg::OP_ER_PAGE, 24'h000400);
    top(sfpc_pkg::OP_ER_CHIP, 24'h0);
    sw(sfpc_pkg::OP_PROT_DIS);
    top(sfpc_pkg::OP_ER_BLOCK, 24'h020000);
    sw(sfpc_pkg::OP_PROT_EN);
    $display("software protect test done");
    // Buffer 2 stays open while buffer 1 feeds a page program
    last_len = 0;
    u_host.frame(hdr(sfpc_pkg::OP_PROG1, 24'h000400), 0, rx);
    o = rnd();
    bw(1, o, 2);
    br(1, o, 2);
    oe_seen = 1'b0;
    u_host.frame(hdr(sfpc_pkg::OP_BUF_RD1, 24'h0), 1, rx);
    chk(oe_seen, 0);
    chk(rdy_w, 0);
    fin();
    chk(last_len, PROG);
    $display("busy buffer test done");
    // Reset pin aborts a program and clears the marks
    u_host.frame(hdr(sfpc_pkg::OP_PROG2, 24'h0), 0, rx);
    u_host.tick(50);
    reset_n = 1'b0;
    u_host.tick(20);
    chk({rdy_w, so_oe}, 2'b10);
    reset_n = 1'b1;
    prot = 64'h0;
    sw_en = 1'b0;
    u_host.tick(6);
    top(sfpc_pkg::OP_ER_SECTOR, 24'h020000);
    // Frame cut short before the address completes
    u_host.frame('{sfpc_pkg::OP_ER_PAGE, 8'h00, 8'h00}, 0, rx);
    u_host.tick(10);
    chk(rdy_w, 1);
    $display("reset and frame test done");
    end_of_test();
  end
endmodule

// file: sfpc_pin_ctrl_properties.sv
// Pin-level concurrent checks for the serial flash pin control block
module sfpc_pin_ctrl_chk #(
  parameter int PROG_CYC = 3000,
  parameter int ER_PAGE_CYC = 2000,
  parameter int ER_BLOCK_CYC = 3000,
  parameter int ER_SECTOR_CYC = 4000,
  parameter int ER_CHIP_CYC = 4096,
  parameter int XFER_CYC = 200,
  parameter int CMP_CYC = 200
) (
  input wire logic CORE_CLK_I, // Core clock
  input wire logic RST_I, // Sync reset, high
  input wire logic SCK_I, // Serial clock pin
  input wire logic CS_N_I, // Chip select pin
  input wire logic SI_I, // Serial data in pin
  input wire logic WP_N_I, // Write protect pin
  input wire logic RESET_N_I, // Reset pin
  input wire logic SO_O, // Serial data out
  input wire logic SO_OE_O, // Serial data out enable
  input wire logic RDY_BUSY_N_O, // Ready/busy level
  input wire logic RDY_BUSY_N_OE_O // Ready/busy pull-down enable
);
  logic [15:0] run_r;
  logic [15:0] run_nxt;
  logic wp_lo_r;
  // Length of the current busy pull-down
  assign run_nxt = RDY_BUSY_N_OE_O ? run_r + 16'h0001 : 16'h0000;
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) run_r <= 16'h0000;
    else run_r <= run_nxt;
  end
  // Write protect level seen as the current busy period starts
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      wp_lo_r <= 1'b0;
    end else if (RDY_BUSY_N_OE_O && run_r == 16'h0000) begin
      wp_lo_r <= !WP_N_I;
    end
  end
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (RST_I);
  a_so_fall_only: assert property (
    SO_OE_O && $past(SO_OE_O) && $changed(SO_O) |-> !$past(SCK_I, 2))
    else $error("serial out moved without a clock fall");
  a_oe_in_frame: assert property (
    SO_OE_O |-> !$past(CS_N_I, 5))
    else $error("serial out driven outside a frame");
  a_so_standby: assert property (
    CS_N_I [*6] |-> !SO_OE_O)
    else $error("serial out driven while deselected");
  a_busy_reset: assert property (
    !RESET_N_I [*4] |-> !RDY_BUSY_N_OE_O)
    else $error("busy held while reset pin low");
  a_oe_reset: assert property (
    !RESET_N_I [*4] |-> !SO_OE_O)
    else $error("serial out driven while reset pin low");
  a_busy_wake: assert property (
    $rose(RESET_N_I) |-> !RDY_BUSY_N_OE_O [*6])
    else $error("busy appeared right after reset release");
  a_busy_launch: assert property (
    $rose(RDY_BUSY_N_OE_O) |-> $past(CS_N_I) && $past(CS_N_I, 2))
    else $error("busy started without chip select high");
  a_busy_length: assert property (
    $fell(RDY_BUSY_N_OE_O) && RESET_N_I |-> run_r inside {PROG_CYC,
      ER_PAGE_CYC, ER_BLOCK_CYC, ER_SECTOR_CYC, ER_CHIP_CYC, XFER_CYC,
      CMP_CYC})
    else $error("busy length matches no operation");
  a_wp_blocks_pe: assert property (
    $fell(RDY_BUSY_N_OE_O) && RESET_N_I && wp_lo_r |->
      run_r inside {XFER_CYC, CMP_CYC})
    else $error("program or erase ran with write protect low");
  a_rdy_level: assert property (
    RDY_BUSY_N_OE_O |-> RDY_BUSY_N_O == 1'b0)
    else $error("busy pull-down drives high");
  c_busy_done: cover property ($fell(RDY_BUSY_N_OE_O) && RESET_N_I);
  c_read: cover property ($rose(SO_OE_O));
  c_abort: cover property (RDY_BUSY_N_OE_O && !RESET_N_I);
endmodule
bind sfpc_pin_ctrl sfpc_pin_ctrl_chk #(
  .PROG_CYC(PROG_CYC), .ER_PAGE_CYC(ER_PAGE_CYC),
  .ER_BLOCK_CYC(ER_BLOCK_CYC), .ER_SECTOR_CYC(ER_SECTOR_CYC),
  .ER_CHIP_CYC(ER_CHIP_CYC), .XFER_CYC(XFER_CYC), .CMP_CYC(CMP_CYC)
) u_chk (
  .CORE_CLK_I(CORE_CLK_I), .RST_I(RST_I), .SCK_I(SCK_I), .CS_N_I(CS_N_I),
  .SI_I(SI_I), .WP_N_I(WP_N_I), .RESET_N_I(RESET_N_I), .SO_O(SO_O),
  .SO_OE_O(SO_OE_O), .RDY_BUSY_N_O(RDY_BUSY_N_O),
  .RDY_BUSY_N_OE_O(RDY_BUSY_N_OE_O)
);

// file: sfpc_pkg.sv
// Shared constants and types for the serial flash pin control block
package sfpc_pkg;

  // Command opcodes understood by the front end
  localparam logic [7:0] OP_BUF_WR1 = 8'h21;
  localparam logic [7:0] OP_BUF_WR2 = 8'h22;
  localparam logic [7:0] OP_BUF_RD1 = 8'h31;
  localparam logic [7:0] OP_BUF_RD2 = 8'h32;
  localparam logic [7:0] OP_PROG1 = 8'h41;
  localparam logic [7:0] OP_PROG2 = 8'h42;
  localparam logic [7:0] OP_XFER1 = 8'h51;
  localparam logic [7:0] OP_XFER2 = 8'h52;
  localparam logic [7:0] OP_CMP1 = 8'h61;
  localparam logic [7:0] OP_CMP2 = 8'h62;
  localparam logic [7:0] OP_ER_PAGE = 8'h71;
  localparam logic [7:0] OP_ER_BLOCK = 8'h72;
  localparam logic [7:0] OP_ER_SECTOR = 8'h73;
  localparam logic [7:0] OP_ER_CHIP = 8'h74;
  localparam logic [7:0] OP_PROT_WR = 8'h81;
  localparam logic [7:0] OP_PROT_EN = 8'h82;
  localparam logic [7:0] OP_PROT_DIS = 8'h83;

  // Address layout: page number above the byte offset
  localparam int ADDR_BYTES = 3;
  localparam int BYTE_AW = 10;
  localparam int PAGE_AW = 13;
  localparam int PAGE_BYTES_DEF = 528;
  localparam int SECTORS_DEF = 64;

  // Self-timed operation lengths in core clock cycles
  localparam int PROG_CYC_DEF = 3000;
  localparam int ER_PAGE_CYC_DEF = 2000;
  localparam int ER_BLOCK_CYC_DEF = 3000;
  localparam int ER_SECTOR_CYC_DEF = 4000;
  localparam int ER_CHIP_CYC_DEF = 4096;
  localparam int XFER_CYC_DEF = 200;
  localparam int CMP_CYC_DEF = 200;
  localparam int BUSY_CW = 16;

  // Pin synchroniser reset image {RESET_N, WP_N, SI, CS_N, SCK}
  localparam logic [4:0] PIN_RST_VAL = 5'h1A;

  // Frame state machine
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_OPC = 7'h02,
    ST_ADDR = 7'h04,
    ST_WDATA = 7'h08,
    ST_RDATA = 7'h10,
    ST_ARM = 7'h20,
    ST_IGNORE = 7'h40
  } sfpc_state_type;

endpackage
